/* logic/timer_status_irq_regs.sv */
// Five-channel timer register bank: counters, general and buffer words,
// status flags and interrupt enables, reached from the CPU port.
// Assumes CPU strobes and timer events are synchronous to sys_clk.
`timescale 1ns/10ps
`default_nettype none

module timer_status_irq_regs (
  // Clock, reset, standby
  input  wire logic                           sys_clk,
  input  wire logic                           reset,
  input  wire logic                           standby,
  // CPU register port
  input  wire logic [timer_pkg::ADDR_W-1:0]   cpu_addr,
  input  wire logic                           cpu_rd,
  input  wire logic                           cpu_wr,
  input  wire logic                           cpu_word,
  input  wire logic [15:0]                    cpu_wdata,
  output logic      [15:0]                    cpu_rdata,
  // Counting events per channel
  input  wire logic [timer_pkg::NUM_CH-1:0]   count_step,
  input  wire logic [timer_pkg::NUM_CH-1:0]   count_down,
  // Mode selections
  input  wire logic                           phase_count_sel,
  input  wire logic                           combo_mode_hi,
  input  wire logic                           combo_mode_lo,
  // General register roles and capture strobes
  input  wire logic [timer_pkg::NUM_CH-1:0]   capture_mode_a,
  input  wire logic [timer_pkg::NUM_CH-1:0]   capture_mode_b,
  input  wire logic [timer_pkg::NUM_CH-1:0]   capture_a,
  input  wire logic [timer_pkg::NUM_CH-1:0]   capture_b,
  // DMA service of request A
  input  wire logic [timer_pkg::NUM_CH-1:0]   dma_ack_a,
  // Interrupt requests
  output logic      [timer_pkg::NUM_CH-1:0]   wrap_irq,
  output logic      [timer_pkg::NUM_CH-1:0]   match_capture_irq_a,
  output logic      [timer_pkg::NUM_CH-1:0]   match_capture_irq_b
);
  import timer_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Address decode helpers

  // Channel number held in the upper address bits
  function automatic logic [2:0] chan_of(input logic [ADDR_W-1:0] a);
    chan_of = a[ADDR_W-1:CH_SHIFT];
  endfunction : chan_of

  // Even word offset within a channel
  function automatic logic [3:0] word_ofs(input logic [ADDR_W-1:0] a);
    word_ofs = {a[3:1], 1'b0};
  endfunction : word_ofs

  // Byte lane select for one 16-bit register: {hi, lo}
  function automatic logic [1:0] lanes(input logic [ADDR_W-1:0] a,
                                       input logic              word,
                                       input logic [3:0]        ofs);
    if (word_ofs(a) != ofs) begin
      lanes = 2'b00;
    end else if (word) begin
      lanes = a[0] ? 2'b00 : 2'b11;
    end else begin
      lanes = a[0] ? 2'b01 : 2'b10;
    end
  endfunction : lanes

  //////////////////////////////////////////////////////////////////////////
  // Shared decode

  logic [2:0]  acc_ch;
  logic        ch_ok;
  logic        byte_acc;
  logic        hit_status;
  logic        hit_irq_en;
  logic [7:0]  byte_wdata;
  logic [1:0]  lane_cnt;
  logic [1:0]  lane_ga;
  logic [1:0]  lane_gb;
  logic [1:0]  lane_ba;
  logic [1:0]  lane_bb;

  // Word data on 15:0; a byte sits on 7:0 whichever address it goes to
  assign acc_ch     = chan_of(cpu_addr);
  assign ch_ok      = (acc_ch < 3'(NUM_CH));
  assign byte_acc   = ~cpu_word;
  assign byte_wdata = cpu_wdata[7:0];
  // The 8-bit registers answer byte access only
  assign hit_status = ch_ok && byte_acc && (cpu_addr[3:0] == OFS_STATUS);
  assign hit_irq_en = ch_ok && byte_acc && (cpu_addr[3:0] == OFS_IRQ_EN);
  // Word or single-byte lanes of the 16-bit registers
  assign lane_cnt   = ch_ok ? lanes(cpu_addr, cpu_word, OFS_COUNTER)
                            : 2'b00;
  assign lane_ga    = ch_ok ? lanes(cpu_addr, cpu_word, OFS_GEN_A) : 2'b00;
  assign lane_gb    = ch_ok ? lanes(cpu_addr, cpu_word, OFS_GEN_B) : 2'b00;
  assign lane_ba    = ch_ok ? lanes(cpu_addr, cpu_word, OFS_BUF_A) : 2'b00;
  assign lane_bb    = ch_ok ? lanes(cpu_addr, cpu_word, OFS_BUF_B) : 2'b00;

  // Up/down capability per channel
  logic [NUM_CH-1:0] updown_ok;

  // Only channel 2 and the complementary pair may count downward
  assign updown_ok = {{2{combo_mode_hi & ~combo_mode_lo}},
                      phase_count_sel, 2'b00};

  //////////////////////////////////////////////////////////////////////////
  // Per-channel datapath and flags

  logic [15:0] counter_q [NUM_CH];
  logic [15:0] gen_a_q   [NUM_CH];
  logic [15:0] gen_b_q   [NUM_CH];
  logic [15:0] buf_a_q   [NUM_CH];
  logic [15:0] buf_b_q   [NUM_CH];
  logic [7:0]  status_q  [NUM_CH];
  logic [7:0]  irq_en_q  [NUM_CH];
  logic [NUM_CH-1:0] stepped_r;

  // Remember a count step so a match is taken on the new value only
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      stepped_r <= '0;
    end else begin
      stepped_r <= count_step;
    end
  end

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    logic        sel;
    logic        going_down;
    logic [15:0] cnt_next;
    logic        wrap_up;
    logic        wrap_down;
    logic        match_a;
    logic        match_b;
    logic        cap_a;
    logic        cap_b;
    logic [2:0]  set_ev;
    logic [2:0]  req;

    assign sel        = (acc_ch == 3'(c));
    // Down request ignored unless the channel runs up/down
    assign going_down = count_down[c] & updown_ok[c];
    assign cnt_next   = going_down ? counter_q[c] - 16'h0001
                                   : counter_q[c] + 16'h0001;
    // Wrap in either direction
    assign wrap_up    = count_step[c] & ~going_down
                      & (counter_q[c] == CNT_MAX);
    assign wrap_down  = count_step[c] & going_down
                      & (counter_q[c] == CNT_ZERO);
    // Compare match on the cycle after the counter reaches the value
    assign match_a    = stepped_r[c] & ~capture_mode_a[c]
                      & (counter_q[c] == gen_a_q[c]);
    assign match_b    = stepped_r[c] & ~capture_mode_b[c]
                      & (counter_q[c] == gen_b_q[c]);
    assign cap_a      = capture_a[c] & capture_mode_a[c];
    assign cap_b      = capture_b[c] & capture_mode_b[c];
    assign set_ev     = {wrap_up | wrap_down, match_b | cap_b, match_a | cap_a};

    // Counter: steps by hardware, CPU write takes priority
    word_reg16 u_counter (
      .sys_clk (sys_clk),
      .reset   (reset),
      .we_hi   (cpu_wr & sel & lane_cnt[1]),
      .we_lo   (cpu_wr & sel & lane_cnt[0]),
      .wdata   (cpu_word ? cpu_wdata : {byte_wdata, byte_wdata}),
      .hw_load (count_step[c]),
      .hw_data (cnt_next),
      .q       (counter_q[c])
    );

    // General register A: loads the counter on capture
    word_reg16 u_gen_a (
      .sys_clk (sys_clk),
      .reset   (reset),
      .we_hi   (cpu_wr & sel & lane_ga[1]),
      .we_lo   (cpu_wr & sel & lane_ga[0]),
      .wdata   (cpu_word ? cpu_wdata : {byte_wdata, byte_wdata}),
      .hw_load (cap_a),
      .hw_data (counter_q[c]),
      .q       (gen_a_q[c])
    );

    // General register B: loads the counter on capture
    word_reg16 u_gen_b (
      .sys_clk (sys_clk),
      .reset   (reset),
      .we_hi   (cpu_wr & sel & lane_gb[1]),
      .we_lo   (cpu_wr & sel & lane_gb[0]),
      .wdata   (cpu_word ? cpu_wdata : {byte_wdata, byte_wdata}),
      .hw_load (cap_b),
      .hw_data (counter_q[c]),
      .q       (gen_b_q[c])
    );

    // Buffer registers: CPU storage only, transfers live elsewhere
    word_reg16 u_buf_a (
      .sys_clk (sys_clk),
      .reset   (reset),
      .we_hi   (cpu_wr & sel & lane_ba[1]),
      .we_lo   (cpu_wr & sel & lane_ba[0]),
      .wdata   (cpu_word ? cpu_wdata : {byte_wdata, byte_wdata}),
      .hw_load (1'b0),
      .hw_data (16'h0000),
      .q       (buf_a_q[c])
    );

    word_reg16 u_buf_b (
      .sys_clk (sys_clk),
      .reset   (reset),
      .we_hi   (cpu_wr & sel & lane_bb[1]),
      .we_lo   (cpu_wr & sel & lane_bb[0]),
      .wdata   (cpu_word ? cpu_wdata : {byte_wdata, byte_wdata}),
      .hw_load (1'b0),
      .hw_data (16'h0000),
      .q       (buf_b_q[c])
    );

    // Independent flags and enables for this channel
    status_channel u_status (
      .sys_clk    (sys_clk),
      .reset      (reset),
      .standby    (standby),
      .hw_set     (set_ev),
      .dma_clr_a  ((c < 4) ? dma_ack_a[c] : 1'b0),
      .rd_status  (cpu_rd & sel & hit_status),
      .wr_status  (cpu_wr & sel & hit_status),
      .wr_irq_en  (cpu_wr & sel & hit_irq_en),
      .wdata      (byte_wdata),
      .status_img (status_q[c]),
      .irq_en_img (irq_en_q[c]),
      .irq_req    (req)
    );

    assign match_capture_irq_a[c] = req[BIT_A];
    assign match_capture_irq_b[c] = req[BIT_B];
    assign wrap_irq[c]            = req[BIT_WRAP];
  end

  //////////////////////////////////////////////////////////////////////////
  // Read data

  logic [15:0] word_sel;
  logic [15:0] rd_mux;
  logic [15:0] rdata_r;
  logic [2:0]  rd_ch;

  assign rd_ch = ch_ok ? acc_ch : 3'd0;

  // Selected 16-bit register; unmapped offsets give zero
  always_comb begin
    case (word_ofs(cpu_addr))
      OFS_COUNTER: word_sel = counter_q[rd_ch];
      OFS_GEN_A:   word_sel = gen_a_q[rd_ch];
      OFS_GEN_B:   word_sel = gen_b_q[rd_ch];
      OFS_BUF_A:   word_sel = buf_a_q[rd_ch];
      OFS_BUF_B:   word_sel = buf_b_q[rd_ch];
      default:     word_sel = 16'h0000;
    endcase
  end

  // Word at even address, byte on the low lane, zero elsewhere
  always_comb begin
    if (!ch_ok) begin
      rd_mux = 16'h0000;
    end else if (hit_status) begin
      rd_mux = {8'h00, status_q[rd_ch]};
    end else if (hit_irq_en) begin
      rd_mux = {8'h00, irq_en_q[rd_ch]};
    end else if (cpu_word) begin
      rd_mux = cpu_addr[0] ? 16'h0000 : word_sel;
    end else begin
      rd_mux = {8'h00, cpu_addr[0] ? word_sel[7:0]
                                   : word_sel[15:8]};
    end
  end

  // Registered read data, held until the next read
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rdata_r <= 16'h0000;
    end else if (cpu_rd) begin
      rdata_r <= rd_mux;
    end
  end

  assign cpu_rdata = rdata_r;

endmodule : timer_status_irq_regs

`default_nettype wire

/* logic/timer_pkg.sv */
// Shared constants for the five-channel timer status and enable bank.
// Assumes byte addressing on the CPU port; 16-bit words are big-endian.
package timer_pkg;

  // Channel count and address layout
  localparam int          NUM_CH       = 5;
  localparam int          ADDR_W       = 7;
  localparam int          CH_SHIFT     = 4;     // 16 bytes per channel
  localparam logic [3:0]  OFS_COUNTER  = 4'h0;
  localparam logic [3:0]  OFS_GEN_A    = 4'h2;
  localparam logic [3:0]  OFS_GEN_B    = 4'h4;
  localparam logic [3:0]  OFS_BUF_A    = 4'h6;
  localparam logic [3:0]  OFS_BUF_B    = 4'h8;
  localparam logic [3:0]  OFS_STATUS   = 4'ha;
  localparam logic [3:0]  OFS_IRQ_EN   = 4'hb;

  // Flag and enable bit positions (same in both 8-bit registers)
  localparam int          BIT_A        = 0;
  localparam int          BIT_B        = 1;
  localparam int          BIT_WRAP     = 2;

  // Reset images; bit 7 is undefined and reads as 0 here
  localparam logic [7:0]  STATUS_RESET = 8'h78;
  localparam logic [7:0]  IRQ_EN_RESET = 8'h78;
  localparam logic [7:0]  FIXED_ONES   = 8'h78;

  // Counter end points
  localparam logic [15:0] CNT_MAX      = 16'hffff;
  localparam logic [15:0] CNT_ZERO     = 16'h0000;

endpackage : timer_pkg

/* logic/word_reg16.sv */
// One 16-bit counter, general or buffer register.
// Assumes the parent decodes byte lanes; a CPU write beats a hardware load.
`timescale 1ns/10ps
`default_nettype none

module word_reg16 (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // CPU byte lanes
  input  wire logic        we_hi,
  input  wire logic        we_lo,
  input  wire logic [15:0] wdata,
  // Hardware load
  input  wire logic        hw_load,
  input  wire logic [15:0] hw_data,
  // Contents
  output logic      [15:0] q
);

  logic [15:0] q_r;
  logic [15:0] q_nxt;

  // Per-lane merge so a byte write keeps the other byte
  assign q_nxt[15:8] = we_hi ? wdata[15:8]
                     : (we_lo ? q_r[15:8] : (hw_load ? hw_data[15:8] : q_r[15:8]));
  assign q_nxt[7:0]  = we_lo ? wdata[7:0]
                     : (we_hi ? q_r[7:0] : (hw_load ? hw_data[7:0] : q_r[7:0]));
  assign q           = q_r;

  // Storage
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      q_r <= 16'h0000;
    end else begin
      q_r <= q_nxt;
    end
  end

endmodule : word_reg16

`default_nettype wire

/* logic/status_channel.sv */
// Status flags and interrupt enables of one channel.
// Assumes set strobes are one-cycle pulses on sys_clk.
`timescale 1ns/10ps
`default_nettype none

module status_channel (
  // Clock, reset, standby
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic       standby,
  // Hardware set and clear events
  input  wire logic [2:0] hw_set,
  input  wire logic       dma_clr_a,
  // CPU access
  input  wire logic       rd_status,
  input  wire logic       wr_status,
  input  wire logic       wr_irq_en,
  input  wire logic [7:0] wdata,
  // Register images and requests
  output logic      [7:0] status_img,
  output logic      [7:0] irq_en_img,
  output logic      [2:0] irq_req
);
  import timer_pkg::*;

  logic [2:0] flag_r;
  logic [2:0] flag_nxt;
  logic [2:0] armed_r;
  logic [2:0] armed_nxt;
  logic [2:0] en_r;
  logic [2:0] sw_clr;
  logic [2:0] dma_clr;

  // Only a 0 after a read-as-1 clears; a written 1 does nothing
  assign sw_clr   = {3{wr_status}} & armed_r & ~wdata[2:0];
  assign dma_clr  = {2'b00, dma_clr_a};
  // Set wins over any clear arriving in the same cycle
  assign flag_nxt = hw_set | (flag_r & ~(sw_clr | dma_clr));
  // Arm on a read that sees 1; any write to status disarms
  assign armed_nxt = wr_status ? 3'b000
                   : (armed_r | ({3{rd_status}} & flag_r)) & flag_nxt;

  assign status_img = FIXED_ONES | {5'b00000, flag_r};
  assign irq_en_img = FIXED_ONES | {5'b00000, en_r};
  assign irq_req    = flag_r & en_r;

  // Flags; standby initialises like reset
  always_ff @(posedge sys_clk) begin
    if (reset || standby) begin
      flag_r  <= STATUS_RESET[2:0];
      armed_r <= 3'b000;
    end else begin
      flag_r  <= flag_nxt;
      armed_r <= armed_nxt;
    end
  end

  // Enables
  always_ff @(posedge sys_clk) begin
    if (reset || standby) begin
      en_r <= IRQ_EN_RESET[2:0];
    end else if (wr_irq_en) begin
      en_r <= wdata[2:0];
    end
  end

endmodule : status_channel

`default_nettype wire

/* tb/timer_status_irq_regs_props.sv */
// Checker for the timer status bank, on top-level ports only.
// Assumes one clock and synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none

module timer_status_irq_regs_props (
  // Clock, reset, standby
  input wire logic                         sys_clk,
  input wire logic                         reset,
  input wire logic                         standby,
  // CPU port
  input wire logic [timer_pkg::ADDR_W-1:0] cpu_addr,
  input wire logic                         cpu_rd,
  input wire logic                         cpu_wr,
  input wire logic                         cpu_word,
  input wire logic [15:0]                  cpu_rdata,
  // Events and requests
  input wire logic [timer_pkg::NUM_CH-1:0] count_step,
  input wire logic [timer_pkg::NUM_CH-1:0] capture_a,
  input wire logic [timer_pkg::NUM_CH-1:0] capture_b,
  input wire logic [timer_pkg::NUM_CH-1:0] dma_ack_a,
  input wire logic [timer_pkg::NUM_CH-1:0] wrap_irq,
  input wire logic [timer_pkg::NUM_CH-1:0] match_capture_irq_a,
  input wire logic [timer_pkg::NUM_CH-1:0] match_capture_irq_b
);
  import timer_pkg::*;
  // Short aliases keep the properties readable
  logic [NUM_CH-1:0] rq_a;
  logic [NUM_CH-1:0] rq_b;
  assign rq_a = match_capture_irq_a;
  assign rq_b = match_capture_irq_b;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  ////////////////////////////////////////////////////////////////////////
  // Outputs idle right after reset
  property p_rst_idle;
    $fell(reset) |-> cpu_rdata == 16'h0000 && (wrap_irq | rq_a | rq_b) == '0;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("not idle");
  // Requests only fall on a CPU write, standby or DMA service
  property p_wrap_hold;
    !cpu_wr && !standby |=> (wrap_irq & $past(wrap_irq)) == $past(wrap_irq);
  endproperty
  a_wrap_hold: assert property (p_wrap_hold) else $error("wrap lost");
  property p_b_hold;
    !cpu_wr && !standby |=> (rq_b & $past(rq_b)) == $past(rq_b);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("b lost");
  // Channel 4 ignores DMA service, so only 0..3 are excused
  property p_a_hold;
    !cpu_wr && !standby && (dma_ack_a & 5'h0f) == 5'h00
      && ($past(dma_ack_a) & 5'h0f) == 5'h00
      |=> (rq_a & $past(rq_a)) == $past(rq_a);
  endproperty
  a_a_hold: assert property (p_a_hold) else $error("a lost");
  // A new request needs its hardware cause or an enable write
  property p_wrap_cause;
    !$past(cpu_wr) |-> (wrap_irq & ~$past(wrap_irq) & ~$past(count_step)) == '0;
  endproperty
  a_wrap_cause: assert property (p_wrap_cause) else $error("wrap cause");
  property p_b_cause;
    !$past(cpu_wr) |-> (rq_b & ~$past(rq_b) & ~$past(capture_b)
      & ~$past(count_step, 2)) == '0;
  endproperty
  a_b_cause: assert property (p_b_cause) else $error("b cause");
  // DMA service of channel 0 drops request A within two cycles
  property p_dma_clr;
    dma_ack_a[0] && !capture_a[0] && !count_step[0] && !$past(count_step[0])
      |-> ##[1:2] !rq_a[0];
  endproperty
  a_dma_clr: assert property (p_dma_clr) else $error("dma clear");
  // Byte read of status or enable shows bits 6..3 as ones
  property p_fixed;
    cpu_rd && !cpu_word && cpu_addr[3:1] == 3'h5 && cpu_addr[6:4] < 3'h5
      |=> cpu_rdata[15:3] == 13'h000f;
  endproperty
  a_fixed: assert property (p_fixed) else $error("fixed bits");
endmodule : timer_status_irq_regs_props

bind timer_status_irq_regs timer_status_irq_regs_props u_props (
  .sys_clk(sys_clk), .reset(reset), .standby(standby),
  .cpu_addr(cpu_addr), .cpu_rd(cpu_rd), .cpu_wr(cpu_wr),
  .cpu_word(cpu_word), .cpu_rdata(cpu_rdata), .count_step(count_step),
  .capture_a(capture_a), .capture_b(capture_b), .dma_ack_a(dma_ack_a),
  .wrap_irq(wrap_irq), .match_capture_irq_a(match_capture_irq_a),
  .match_capture_irq_b(match_capture_irq_b)
);
`default_nettype wire

/* tb/dma_partner.sv */
// DMA side of request A: acknowledges requests on served channels.
// Assumes requests are levels on sys_clk; LAG sets how slow it answers.
`timescale 1ns/10ps
`default_nettype none

module dma_partner #(
  parameter int LAG = 2
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset,
  // Requests, served channels, acknowledge
  input  wire logic [4:0] irq_a,
  input  wire logic [4:0] serve,
  output logic      [4:0] ack
);
  logic [4:0] pend;
  // Sample at the falling edge to stay clear of the flag updates
  initial begin
    ack = '0;
    forever begin
      @(negedge sys_clk);
      if (!reset && (irq_a & serve) != 5'h00) begin
        pend = irq_a & serve;
        repeat (LAG) @(posedge sys_clk);
        ack <= pend;
        @(posedge sys_clk);
        ack <= '0;
        repeat (2) @(posedge sys_clk);
      end
    end
  end
endmodule : dma_partner
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for the timer status bank.
// Assumes the DMA partner model and the bound checker beside the design.
`timescale 1ns/10ps
`default_nettype none

module testbench;
  import timer_pkg::*;
  logic              sys_clk, reset, standby, cpu_rd, cpu_wr, cpu_word;
  logic              phase_count_sel, combo_mode_hi, combo_mode_lo;
  logic [ADDR_W-1:0] cpu_addr;
  logic [15:0]       cpu_wdata, cpu_rdata, irqs;
  logic [NUM_CH-1:0] count_step, count_down, capture_mode_a, capture_mode_b;
  logic [NUM_CH-1:0] capture_a, capture_b, dma_ack_a, serve;
  logic [NUM_CH-1:0] wrap_irq, match_capture_irq_a, match_capture_irq_b;
  int                failures, check_count;
  // Requests packed as b, a, wrap
  assign irqs = {1'b0, match_capture_irq_b, match_capture_irq_a, wrap_irq};

  timer_status_irq_regs DUT (
    .sys_clk(sys_clk), .reset(reset), .standby(standby),
    .cpu_addr(cpu_addr), .cpu_rd(cpu_rd), .cpu_wr(cpu_wr),
    .cpu_word(cpu_word), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
    .count_step(count_step), .count_down(count_down),
    .phase_count_sel(phase_count_sel), .combo_mode_hi(combo_mode_hi),
    .combo_mode_lo(combo_mode_lo), .capture_mode_a(capture_mode_a),
    .capture_mode_b(capture_mode_b), .capture_a(capture_a),
    .capture_b(capture_b), .dma_ack_a(dma_ack_a), .wrap_irq(wrap_irq),
    .match_capture_irq_a(match_capture_irq_a),
    .match_capture_irq_b(match_capture_irq_b)
  );
  dma_partner u_dma (
    .sys_clk(sys_clk), .reset(reset), .irq_a(match_capture_irq_a),
    .serve(serve), .ack(dma_ack_a)
  );

  ////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One access, held up to the single edge that takes it
  task automatic wr(input logic [2:0] ch, input logic [3:0] ofs,
                    input logic wd, input logic [15:0] d, input logic r = 0);
    @(posedge sys_clk);
    cpu_addr <= {ch, ofs};
    cpu_word <= wd;
    cpu_rd <= r;
    cpu_wr <= !r;
    cpu_wdata <= d;
    @(posedge sys_clk);
    cpu_rd <= 1'b0;
    cpu_wr <= 1'b0;
    // Return off the edge so callers see the settled result
    @(negedge sys_clk);
  endtask : wr
  task automatic rd(input logic [2:0] ch, input logic [3:0] ofs,
                    input logic wd, input logic [15:0] exp);
    wr(ch, ofs, wd, 16'h0000, 1'b1);
    chk(cpu_rdata, exp);
  endtask : rd
  task automatic step(input logic [4:0] m, input logic [4:0] dn);
    @(posedge sys_clk);
    count_step <= m;
    count_down <= dn;
    @(posedge sys_clk);
    count_step <= '0;
    repeat (2) @(negedge sys_clk);
  endtask : step
  task automatic print_verdict();
    if (failures == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  // Hang guard, far beyond the 170 or so cycles the run needs
  initial begin
    repeat (3000) @(posedge sys_clk);
    failures++;
    print_verdict();
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    reset = 1'b1;
    {standby, cpu_rd, cpu_wr, cpu_word, phase_count_sel, combo_mode_hi,
     combo_mode_lo, cpu_addr, cpu_wdata, count_step, count_down,
     capture_mode_a, capture_mode_b, capture_a, capture_b, serve} = '0;
    failures = 0;
    check_count = 0;
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    // Reset images of every channel
    for (int c = 0; c < 5; c++) begin
      rd(c[2:0], OFS_STATUS, 1'b0, 16'h0078);
      rd(c[2:0], OFS_IRQ_EN, 1'b0, 16'h0078);
    end
    // Word and byte lanes of a counter and of buffer B; word access to status and channel 5 read zero
    wr(3'h0, OFS_COUNTER, 1'b1, 16'h1234);
    rd(3'h0, OFS_COUNTER, 1'b1, 16'h1234);
    rd(3'h0, OFS_COUNTER, 1'b0, 16'h0012);
    wr(3'h0, 4'h1, 1'b0, 16'h00ab);
    rd(3'h0, OFS_COUNTER, 1'b1, 16'h12ab);
    wr(3'h2, OFS_BUF_B, 1'b1, 16'h5aa5);
    rd(3'h2, OFS_BUF_B, 1'b0, 16'h005a);
    rd(3'h0, OFS_STATUS, 1'b1, 16'h0000);
    rd(3'h5, OFS_STATUS, 1'b0, 16'h0000);
    // Upward wrap; down request ignored outside up/down modes
    wr(3'h0, OFS_COUNTER, 1'b1, 16'hffff);
    wr(3'h0, OFS_IRQ_EN, 1'b0, 16'h00ff);
    rd(3'h0, OFS_IRQ_EN, 1'b0, 16'h007f);
    step(5'h01, 5'h01);
    // Both general registers still 0, so they match the wrapped count
    chk(irqs, 16'h0421);
    rd(3'h0, OFS_COUNTER, 1'b1, 16'h0000);
    // Write 0 without a prior read must not clear
    wr(3'h0, OFS_STATUS, 1'b0, 16'h0078);
    rd(3'h1, OFS_STATUS, 1'b0, 16'h0078);
    rd(3'h0, OFS_STATUS, 1'b0, 16'h007f);
    wr(3'h0, OFS_STATUS, 1'b0, 16'h0078);
    chk(irqs, 16'h0000);
    wr(3'h0, OFS_STATUS, 1'b0, 16'h00ff);
    rd(3'h0, OFS_STATUS, 1'b0, 16'h0078);
    // Downward wrap on channels 2 and 3 only, enables left off
    @(posedge sys_clk);
    phase_count_sel <= 1'b1;
    combo_mode_hi <= 1'b1;
    for (int c = 1; c < 4; c++)
      wr(c[2:0], OFS_COUNTER, 1'b1, 16'h0000);
    step(5'h0e, 5'h0e);
    chk(irqs, 16'h0000);
    rd(3'h1, OFS_COUNTER, 1'b1, 16'h0001);
    rd(3'h2, OFS_COUNTER, 1'b1, 16'hffff);
    rd(3'h2, OFS_STATUS, 1'b0, 16'h007c);
    rd(3'h3, OFS_STATUS, 1'b0, 16'h007c);
    // Both combination bits set: channel 4 keeps counting up
    @(posedge sys_clk);
    combo_mode_lo <= 1'b1;
    step(5'h10, 5'h10);
    rd(3'h4, OFS_COUNTER, 1'b1, 16'h0001);
    rd(3'h4, OFS_STATUS, 1'b0, 16'h0078);
    @(posedge sys_clk);
    {phase_count_sel, combo_mode_hi, combo_mode_lo} <= 3'b000;
    // Compare B then A on channel 1
    wr(3'h1, OFS_GEN_A, 1'b1, 16'h0003);
    wr(3'h1, OFS_GEN_B, 1'b1, 16'h0002);
    wr(3'h1, OFS_IRQ_EN, 1'b0, 16'h007b);
    step(5'h02, 5'h00);
    chk(irqs, 16'h0800);
    step(5'h02, 5'h00);
    chk(irqs, 16'h0840);
    rd(3'h1, OFS_STATUS, 1'b0, 16'h007b);
    wr(3'h1, OFS_STATUS, 1'b0, 16'h0079);
    rd(3'h1, OFS_STATUS, 1'b0, 16'h0079);
    chk(irqs, 16'h0040);
    wr(3'h1, OFS_IRQ_EN, 1'b0, 16'h0078);
    chk(irqs, 16'h0000);
    // Captures; DMA serves channels 0 and 4, only 0 may clear
    wr(3'h0, OFS_COUNTER, 1'b1, 16'h0abc);
    wr(3'h4, OFS_COUNTER, 1'b1, 16'h0321);
    wr(3'h0, OFS_IRQ_EN, 1'b0, 16'h0079);
    wr(3'h4, OFS_IRQ_EN, 1'b0, 16'h0079);
    @(posedge sys_clk);
    {capture_mode_a, capture_mode_b, serve} <= {5'h11, 5'h10, 5'h11};
    {capture_a, capture_b} <= {5'h11, 5'h10};
    @(posedge sys_clk);
    {capture_a, capture_b} <= '0;
    repeat (8) @(posedge sys_clk);
    rd(3'h0, OFS_GEN_A, 1'b1, 16'h0abc);
    rd(3'h0, OFS_STATUS, 1'b0, 16'h0078);
    rd(3'h4, OFS_STATUS, 1'b0, 16'h007b);
    rd(3'h4, OFS_GEN_B, 1'b1, 16'h0321);
    // Capture on the clearing edge keeps flag B; armed flag A clears
    @(posedge sys_clk);
    capture_b <= 5'h10;
    wr(3'h4, OFS_STATUS, 1'b0, 16'h0078);
    @(posedge sys_clk);
    capture_b <= '0;
    rd(3'h4, OFS_STATUS, 1'b0, 16'h007a);
    // Standby reinitialises status and enables
    @(posedge sys_clk);
    serve <= '0;
    standby <= 1'b1;
    @(posedge sys_clk);
    standby <= 1'b0;
    rd(3'h4, OFS_STATUS, 1'b0, 16'h0078);
    rd(3'h4, OFS_IRQ_EN, 1'b0, 16'h0078);
    chk(irqs, 16'h0000);
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
